/* hdl/peak_power_map.svh */
// offsets, field positions, reset values and timing figures of the peak power option register
`ifndef PEAK_POWER_MAP_SVH
`define PEAK_POWER_MAP_SVH

// command address and power-on value
`define PPO_CMD_ADDR 8'h31
`define PPO_RESET_VAL 16'h02b7

// field positions
`define PPO_OVLD_WIN_HI 15
`define PPO_OVLD_WIN_LO 14
`define PPO_SURGE_CURR_BIT 13
`define PPO_SURGE_DROOP_BIT 12
`define PPO_OVLD_FLAG_BIT 11
`define PPO_RECOV_FLAG_BIT 10
`define PPO_PERIOD_HI 9
`define PPO_PERIOD_LO 8
`define PPO_MERGE_BIT 7
`define PPO_MON_DIR_BIT 6
`define PPO_LOW_SW_BIT 5
`define PPO_IN_SENSE_BIT 4
`define PPO_IN_OC_EN_BIT 3
`define PPO_IN_OC_RATIO_BIT 2
`define PPO_DIS_OC_EN_BIT 1
`define PPO_DIS_OC_RATIO_BIT 0

// clock rate and unit conversion
`define PPO_CLK_MHZ 200
`define PPO_US_PER_MS 1000

// overload window in ms per code
`define PPO_OVLD_MS_0 32'd1
`define PPO_OVLD_MS_1 32'd2
`define PPO_OVLD_MS_2 32'd10
`define PPO_OVLD_MS_3 32'd20

// overload plus recovery period in ms per code
`define PPO_PERIOD_MS_0 32'd5
`define PPO_PERIOD_MS_1 32'd10
`define PPO_PERIOD_MS_2 32'd20
`define PPO_PERIOD_MS_3 32'd40

// input overcurrent blank-out in us
`define PPO_BLANK_US 100

`endif

/* hdl/peak_power_pkg.sv */
// types shared by the peak power option logic
package peak_power_pkg;

  // surge sequencer states, gray coded along idle, overload, recovery
  typedef enum logic [1:0] {
    SURGE_IDLE = 2'b00,
    SURGE_OVERLOAD = 2'b01,
    SURGE_RECOVERY = 2'b11
  } surge_state_type;

endpackage

/* hdl/pin_sync.sv */
// two-flop synchroniser bank for pin inputs
`timescale 1ns/1ps

module pin_sync #(
  parameter int unsigned WIDTH = 1
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  // asynchronous inputs and synchronised outputs
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_q;

  // first stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (!rstn) begin
      meta_q <= '0;
      q <= '0;
    end else if (ce) begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule

/* hdl/peak_power_options.sv */
// peak power and protection option register with surge sequencer and overcurrent trips
`timescale 1ns/1ps
`include "peak_power_map.svh"

// Overview of operation
// - bits 15:14 pick overload window 1, 2, 10 or 20 ms; reset 00
// - bit 13 arms surge on input current, bit 12 on rail droop; both 0 disables
// - adapter removal clears both surge arm bits
// - bit 11 reads overload phase; host writing 0 ends that phase
// - bit 10 reads recovery phase; host writing 0 ends that phase
// - bits 9:8 pick cycle period 5, 10, 20 or 40 ms; reset 10
// - overload window longer than period means no recovery phase
// - bit 7 set uses lower of pin limit and register limit, else register only
// - bit 6 picks monitor direction: 0 discharge, 1 charge
// - bit 5 low switch trip level: 0 is 210 mV, 1 is 150 mV
// - bit 4 input sense trip level: 0 is 280 mV, 1 is 150 mV
// - bit 3 lets input overcurrent stop the converter after 100 us blank-out
// - bit 2 input overcurrent ratio: 0 is 133 percent, 1 is 200 percent
// - bit 1 lets discharge overcurrent stop the converter; set at reset
// - bit 0 discharge overcurrent ratio: 0 is 133 percent, 1 is 200 percent
// - register answers command 31h and powers up as 02b7h
// - software register reset restores power-on value, then its control bit clears
module peak_power_options #(
  parameter int unsigned MS_CYCLES = `PPO_CLK_MHZ * `PPO_US_PER_MS,
  parameter int unsigned BLANK_CYCLES = `PPO_BLANK_US * `PPO_CLK_MHZ
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  // command port from the smbus front end
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_addr,
  input wire logic [15:0] cmd_wdata,
  output logic rsp_valid,
  output logic rsp_ack,
  output logic [15:0] rsp_rdata,
  // software register reset handshake
  input wire logic soft_reset_req,
  output logic reg_reset_clear,
  // pins and comparators from outside the clock domain
  input wire logic adapter_present,
  input wire logic input_current_overshoot,
  input wire logic rail_droop,
  input wire logic [7:0] limit_pin,
  input wire logic input_overcurrent,
  input wire logic discharge_overcurrent,
  // limit from the neighbouring register, same clock
  input wire logic [7:0] input_limit_setting,
  // surge sequencer status
  output logic overload_active,
  output logic recovery_active,
  // analog configuration outputs
  output logic [7:0] input_limit_effective,
  output logic current_monitor_direction,
  output logic low_switch_trip_level,
  output logic input_sense_trip_level,
  output logic input_overcurrent_ratio,
  output logic discharge_overcurrent_ratio,
  output logic converter_disable
);

  logic [15:0] cfg_q;
  logic [15:0] cfg_d;
  logic [15:0] read_word;
  logic [12:0] sync_q;
  logic adapter_s;
  logic overshoot_s;
  logic droop_s;
  logic in_oc_s;
  logic dis_oc_s;
  logic [7:0] limit_pin_s;
  logic adapter_prev_q;
  logic adapter_fall;
  logic addr_hit;
  logic wr_hit;
  logic clr_overload;
  logic clr_recovery;
  logic trigger;
  peak_power_pkg::surge_state_type state_q;
  peak_power_pkg::surge_state_type state_d;
  logic [31:0] timer_q;
  logic [31:0] timer_d;
  logic [31:0] blank_cnt_q;
  logic input_oc_trip_q;
  logic rsp_valid_q;
  logic rsp_ack_q;
  logic [15:0] rsp_rdata_q;
  logic reg_reset_clear_q;
  logic overload_active_q;
  logic recovery_active_q;
  logic [7:0] limit_eff_q;
  logic converter_disable_q;

  // overload window in ms for a field code
  function automatic logic [31:0] ovld_ms(input logic [1:0] code);
    case (code)
      2'b00: ovld_ms = `PPO_OVLD_MS_0;
      2'b01: ovld_ms = `PPO_OVLD_MS_1;
      2'b10: ovld_ms = `PPO_OVLD_MS_2;
      default: ovld_ms = `PPO_OVLD_MS_3;
    endcase
  endfunction

  // cycle period in ms for a field code
  function automatic logic [31:0] period_ms(input logic [1:0] code);
    case (code)
      2'b00: period_ms = `PPO_PERIOD_MS_0;
      2'b01: period_ms = `PPO_PERIOD_MS_1;
      2'b10: period_ms = `PPO_PERIOD_MS_2;
      default: period_ms = `PPO_PERIOD_MS_3;
    endcase
  endfunction

  // pin inputs pass two flops before any use
  pin_sync #(
    .WIDTH(13)
  ) u_sync (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .d({adapter_present, input_current_overshoot, rail_droop, input_overcurrent,
        discharge_overcurrent, limit_pin}),
    .q(sync_q)
  );

  assign {adapter_s, overshoot_s, droop_s, in_oc_s, dis_oc_s, limit_pin_s} = sync_q;

  // command decode
  assign addr_hit = cmd_valid && (cmd_addr == `PPO_CMD_ADDR);
  assign wr_hit = addr_hit && cmd_write;
  assign clr_overload = wr_hit && !cmd_wdata[`PPO_OVLD_FLAG_BIT];
  assign clr_recovery = wr_hit && !cmd_wdata[`PPO_RECOV_FLAG_BIT];
  assign adapter_fall = adapter_prev_q && !adapter_s;
  assign trigger = (cfg_q[`PPO_SURGE_CURR_BIT] && overshoot_s) ||
                   (cfg_q[`PPO_SURGE_DROOP_BIT] && droop_s);

  // adapter level history for removal detection
  always_ff @(posedge clk) begin
    if (!rstn) begin
      adapter_prev_q <= 1'b0;
    end else if (ce) begin
      adapter_prev_q <= adapter_s;
    end
  end

  // next register value: host write, then adapter removal on top
  always_comb begin
    cfg_d = cfg_q;
    if (wr_hit) begin
      cfg_d = cmd_wdata;
      cfg_d[`PPO_OVLD_FLAG_BIT] = 1'b0; // flags live in the sequencer
      cfg_d[`PPO_RECOV_FLAG_BIT] = 1'b0;
    end
    if (adapter_fall) begin
      cfg_d[`PPO_SURGE_CURR_BIT] = 1'b0;
      cfg_d[`PPO_SURGE_DROOP_BIT] = 1'b0;
    end
  end

  // option storage with power-on and software reset
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cfg_q <= `PPO_RESET_VAL;
    end else if (ce) begin
      if (soft_reset_req) begin
        cfg_q <= `PPO_RESET_VAL;
      end else begin
        cfg_q <= cfg_d;
      end
    end
  end

  // self-clearing pulse back to the reset control bit
  always_ff @(posedge clk) begin
    if (!rstn) begin
      reg_reset_clear_q <= 1'b0;
    end else if (ce) begin
      reg_reset_clear_q <= soft_reset_req;
    end
  end

  // read image: stored fields plus live phase flags
  always_comb begin
    read_word = cfg_q;
    read_word[`PPO_OVLD_FLAG_BIT] = (state_q == peak_power_pkg::SURGE_OVERLOAD);
    read_word[`PPO_RECOV_FLAG_BIT] = (state_q == peak_power_pkg::SURGE_RECOVERY);
  end

  // registered answer, nack on a foreign command
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rsp_valid_q <= 1'b0;
      rsp_ack_q <= 1'b0;
      rsp_rdata_q <= 16'h0000;
    end else if (ce) begin
      rsp_valid_q <= cmd_valid;
      rsp_ack_q <= addr_hit;
      rsp_rdata_q <= (addr_hit && !cmd_write) ? read_word : 16'h0000;
    end
  end

  // surge sequencer: overload window, then recovery to fill the period
  always_comb begin
    state_d = state_q;
    timer_d = timer_q;
    case (state_q)
      peak_power_pkg::SURGE_IDLE: begin
        if (trigger) begin
          state_d = peak_power_pkg::SURGE_OVERLOAD;
          timer_d = 32'(ovld_ms(cfg_q[15:14]) * MS_CYCLES) - 32'd1;
        end
      end
      peak_power_pkg::SURGE_OVERLOAD: begin
        if (clr_overload) begin
          state_d = peak_power_pkg::SURGE_IDLE;
          timer_d = 32'd0;
        end else if (timer_q == 32'd0) begin
          if (ovld_ms(cfg_q[15:14]) < period_ms(cfg_q[9:8])) begin
            state_d = peak_power_pkg::SURGE_RECOVERY;
            timer_d = 32'((period_ms(cfg_q[9:8]) - ovld_ms(cfg_q[15:14])) * MS_CYCLES)
                      - 32'd1;
          end else begin
            state_d = peak_power_pkg::SURGE_IDLE;
          end
        end else begin
          timer_d = timer_q - 32'd1;
        end
      end
      peak_power_pkg::SURGE_RECOVERY: begin
        if (clr_recovery || (timer_q == 32'd0)) begin
          state_d = peak_power_pkg::SURGE_IDLE;
          timer_d = 32'd0;
        end else begin
          timer_d = timer_q - 32'd1;
        end
      end
      default: begin
        state_d = peak_power_pkg::SURGE_IDLE;
        timer_d = 32'd0;
      end
    endcase
  end

  // sequencer state and phase outputs
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_q <= peak_power_pkg::SURGE_IDLE;
      timer_q <= 32'd0;
      overload_active_q <= 1'b0;
      recovery_active_q <= 1'b0;
    end else if (ce) begin
      state_q <= soft_reset_req ? peak_power_pkg::SURGE_IDLE : state_d;
      timer_q <= timer_d;
      overload_active_q <= !soft_reset_req && (state_d == peak_power_pkg::SURGE_OVERLOAD);
      recovery_active_q <= !soft_reset_req && (state_d == peak_power_pkg::SURGE_RECOVERY);
    end
  end

  // input overcurrent must persist through the blank-out before tripping
  always_ff @(posedge clk) begin
    if (!rstn) begin
      blank_cnt_q <= 32'd0;
      input_oc_trip_q <= 1'b0;
    end else if (ce) begin
      if (!(cfg_q[`PPO_IN_OC_EN_BIT] && in_oc_s)) begin
        blank_cnt_q <= 32'd0;
        input_oc_trip_q <= 1'b0;
      end else if (blank_cnt_q >= BLANK_CYCLES - 32'd1) begin
        input_oc_trip_q <= 1'b1;
      end else begin
        blank_cnt_q <= blank_cnt_q + 32'd1;
      end
    end
  end

  // converter stop and effective input limit
  always_ff @(posedge clk) begin
    if (!rstn) begin
      converter_disable_q <= 1'b0;
      limit_eff_q <= 8'h00;
    end else if (ce) begin
      converter_disable_q <= input_oc_trip_q ||
                             (cfg_q[`PPO_DIS_OC_EN_BIT] && dis_oc_s);
      if (cfg_q[`PPO_MERGE_BIT] && (limit_pin_s < input_limit_setting)) begin
        limit_eff_q <= limit_pin_s;
      end else begin
        limit_eff_q <= input_limit_setting;
      end
    end
  end

  // outputs straight from flops
  assign rsp_valid = rsp_valid_q;
  assign rsp_ack = rsp_ack_q;
  assign rsp_rdata = rsp_rdata_q;
  assign reg_reset_clear = reg_reset_clear_q;
  assign overload_active = overload_active_q;
  assign recovery_active = recovery_active_q;
  assign input_limit_effective = limit_eff_q;
  assign converter_disable = converter_disable_q;
  assign current_monitor_direction = cfg_q[`PPO_MON_DIR_BIT];
  assign low_switch_trip_level = cfg_q[`PPO_LOW_SW_BIT];
  assign input_sense_trip_level = cfg_q[`PPO_IN_SENSE_BIT];
  assign input_overcurrent_ratio = cfg_q[`PPO_IN_OC_RATIO_BIT];
  assign discharge_overcurrent_ratio = cfg_q[`PPO_DIS_OC_RATIO_BIT];

  // checks on the register, sequencer and trips
  chk_power_on_value: assert property (@(posedge clk) disable iff (!rstn)
    !$past(rstn) |-> cfg_q == `PPO_RESET_VAL && state_q == peak_power_pkg::SURGE_IDLE)
    else $error("power-on value wrong");
  chk_soft_reset: assert property (@(posedge clk) disable iff (!rstn)
    ce && soft_reset_req |=> cfg_q == `PPO_RESET_VAL && reg_reset_clear
    && state_q == peak_power_pkg::SURGE_IDLE && !overload_active && !recovery_active)
    else $error("software reset did not restore value");
  chk_adapter_disarm: assert property (@(posedge clk) disable iff (!rstn)
    ce && adapter_fall |=> cfg_q[13:12] == 2'b00)
    else $error("arm bits survived adapter removal");
  chk_disarmed_idle: assert property (@(posedge clk) disable iff (!rstn)
    ce && state_q == peak_power_pkg::SURGE_IDLE && cfg_q[13:12] == 2'b00
    |=> state_q == peak_power_pkg::SURGE_IDLE)
    else $error("surge started while disarmed");
  chk_overload_load: assert property (@(posedge clk) disable iff (!rstn)
    ce && state_q == peak_power_pkg::SURGE_IDLE && trigger && !soft_reset_req
    |=> overload_active && timer_q == 32'(ovld_ms($past(cfg_q[15:14])) * MS_CYCLES) - 32'd1)
    else $error("overload window not loaded");
  chk_recovery_load: assert property (@(posedge clk) disable iff (!rstn)
    ce && state_q == peak_power_pkg::SURGE_OVERLOAD && timer_q == 32'd0 && !clr_overload
    && ovld_ms(cfg_q[15:14]) < period_ms(cfg_q[9:8]) && !soft_reset_req
    |=> recovery_active && timer_q == 32'((period_ms($past(cfg_q[9:8]))
        - ovld_ms($past(cfg_q[15:14]))) * MS_CYCLES) - 32'd1)
    else $error("recovery time not loaded");
  chk_no_recovery: assert property (@(posedge clk) disable iff (!rstn)
    ce && state_q == peak_power_pkg::SURGE_OVERLOAD && timer_q == 32'd0
    && ovld_ms(cfg_q[15:14]) >= period_ms(cfg_q[9:8])
    |=> state_q == peak_power_pkg::SURGE_IDLE && !recovery_active)
    else $error("recovery entered with long window");
  chk_overload_exit: assert property (@(posedge clk) disable iff (!rstn)
    ce && clr_overload && state_q == peak_power_pkg::SURGE_OVERLOAD
    |=> !overload_active ##1 !rsp_rdata[11])
    else $error("host could not end overload");
  chk_recovery_exit: assert property (@(posedge clk) disable iff (!rstn)
    ce && clr_recovery && state_q == peak_power_pkg::SURGE_RECOVERY
    |=> state_q == peak_power_pkg::SURGE_IDLE && !recovery_active)
    else $error("host could not end recovery");
  chk_flag_readback: assert property (@(posedge clk) disable iff (!rstn)
    ce && addr_hit && !cmd_write
    |=> rsp_ack && rsp_rdata[11] == $past(state_q == peak_power_pkg::SURGE_OVERLOAD)
        && rsp_rdata[10] == $past(state_q == peak_power_pkg::SURGE_RECOVERY))
    else $error("phase flags read back wrong");
  chk_ones_ignored: assert property (@(posedge clk) disable iff (!rstn)
    ce && wr_hit && cmd_wdata[11] && cmd_wdata[10] && state_q == peak_power_pkg::SURGE_IDLE
    && !trigger |=> state_q == peak_power_pkg::SURGE_IDLE)
    else $error("writing one started a phase");
  chk_limit_merge: assert property (@(posedge clk) disable iff (!rstn)
    ce && cfg_q[7] |=> input_limit_effective <= $past(input_limit_setting)
    && input_limit_effective <= $past(limit_pin_s))
    else $error("merged limit not the lower one");
  chk_blank_out: assert property (@(posedge clk) disable iff (!rstn)
    $rose(input_oc_trip_q) |-> $past(blank_cnt_q) >= BLANK_CYCLES - 32'd1
    && $past(cfg_q[3]) && $past(in_oc_s))
    else $error("input trip before blank-out");
  chk_discharge_trip: assert property (@(posedge clk) disable iff (!rstn)
    ce && cfg_q[1] && dis_oc_s |=> converter_disable)
    else $error("discharge overcurrent did not stop converter");

endmodule

/* tb/ppo_host_model.sv */
// host model that issues whole 16-bit commands to the option register
`timescale 1ns/1ps

module ppo_host_model (
  // clock
  input wire logic clk,
  // command port
  output logic cmd_valid,
  output logic cmd_write,
  output logic [7:0] cmd_addr,
  output logic [15:0] cmd_wdata,
  // response port
  input wire logic rsp_valid,
  input wire logic rsp_ack,
  input wire logic [15:0] rsp_rdata
);
  // idle command port at time zero
  initial begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_addr = 8'h00;
    cmd_wdata = 16'h0000;
  end

  // request held to the taking edge; released address and data lines show inverted values
  // a host write of 0 to a phase flag is how it ends that phase
  task automatic xfer(input logic wr, input logic [7:0] addr, input logic [15:0] wdata,
                      input int gap, output logic got, output logic ack,
                      output logic [15:0] rdata);
    repeat (gap) @(posedge clk);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_write <= wr;
    cmd_addr <= addr;
    cmd_wdata <= wdata;
    @(posedge clk);
    cmd_valid <= 1'b0;
    cmd_addr <= ~addr;
    cmd_wdata <= ~wdata;
    #1;
    got = rsp_valid;
    ack = rsp_ack;
    rdata = rsp_rdata;
  endtask
endmodule

/* tb/peak_power_options_tb.sv */
// self-checking testbench of the peak power option register
`timescale 1ns/1ps

module peak_power_options_tb;
  localparam int MS = 4;
  localparam int BLANK = 5;
  logic clk, rstn, ce, soft_reset_req, adapter_present, input_current_overshoot, rail_droop;
  logic input_overcurrent, discharge_overcurrent, rsp_valid, rsp_ack, reg_reset_clear;
  logic overload_active, recovery_active, current_monitor_direction, low_switch_trip_level;
  logic input_sense_trip_level, input_overcurrent_ratio, discharge_overcurrent_ratio;
  logic converter_disable, cmd_valid, cmd_write;
  logic [7:0] cmd_addr, limit_pin, input_limit_setting, input_limit_effective;
  logic [15:0] cmd_wdata, rsp_rdata;
  int fails = 0;
  int checks = 0;

  // clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  peak_power_options #(.MS_CYCLES(MS), .BLANK_CYCLES(BLANK)) dut (.clk(clk), .rstn(rstn),
    .ce(ce), .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_ack(rsp_ack), .rsp_rdata(rsp_rdata),
    .soft_reset_req(soft_reset_req), .reg_reset_clear(reg_reset_clear),
    .adapter_present(adapter_present), .input_current_overshoot(input_current_overshoot),
    .rail_droop(rail_droop), .limit_pin(limit_pin), .input_overcurrent(input_overcurrent),
    .discharge_overcurrent(discharge_overcurrent), .input_limit_setting(input_limit_setting),
    .overload_active(overload_active), .recovery_active(recovery_active),
    .input_limit_effective(input_limit_effective),
    .current_monitor_direction(current_monitor_direction),
    .low_switch_trip_level(low_switch_trip_level),
    .input_sense_trip_level(input_sense_trip_level),
    .input_overcurrent_ratio(input_overcurrent_ratio),
    .discharge_overcurrent_ratio(discharge_overcurrent_ratio),
    .converter_disable(converter_disable));

  ppo_host_model host (.clk(clk), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_ack(rsp_ack),
    .rsp_rdata(rsp_rdata));

  // verdict and end of run
  task automatic end_of_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // comparison helpers
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic ok(input string what, input logic c);
    check(what, {15'h0, c}, 16'h0001);
  endtask

  task automatic bound(input int n, input int lim);
    check("wait bound", 16'(n >= lim), 16'h0000);
    if (n >= lim) begin
      end_of_test();
    end
  endtask

  // cycle, pin and register helpers
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic drop();
    @(posedge clk);
    input_current_overshoot <= 1'b0;
    rail_droop <= 1'b0;
    #1;
  endtask

  task automatic wr(input logic [15:0] v);
    logic g, a;
    logic [15:0] d;
    host.xfer(1'b1, 8'h31, v, 0, g, a, d);
    check("write ack", {14'h0, g, a}, 16'h0003);
  endtask

  task automatic rd(output logic [15:0] d);
    logic g, a;
    host.xfer(1'b0, 8'h31, 16'h0000, 1, g, a, d);
    check("read ack", {14'h0, g, a}, 16'h0003);
  endtask

  task automatic fire(input int pin);
    int n;
    @(posedge clk);
    if (pin == 0) input_current_overshoot <= 1'b1;
    else rail_droop <= 1'b1;
    #1;
    for (n = 0; n < 20 && overload_active !== 1'b1; n++) tick(1);
    bound(n, 20);
  endtask

  // scenarios
  task automatic t_reset();
    logic [15:0] d;
    rd(d);
    check("power-on value", d, 16'h02b7);
    check("reset outputs", {10'h0, current_monitor_direction, low_switch_trip_level,
      input_sense_trip_level, input_overcurrent_ratio, discharge_overcurrent_ratio,
      converter_disable}, 16'h001e);
    check("reset limit", {8'h0, input_limit_effective}, 16'h0020);
    $display("test reset done");
  endtask

  task automatic t_config();
    logic [15:0] pats [3] = '{16'h0000, 16'h0055, 16'h00a2};
    logic [15:0] d, v;
    for (int i = 0; i < 3; i++) begin
      v = pats[i];
      wr(v);
      tick(4);
      check("config outputs", {11'h0, current_monitor_direction, low_switch_trip_level,
        input_sense_trip_level, input_overcurrent_ratio, discharge_overcurrent_ratio},
        {11'h0, v[6], v[5], v[4], v[2], v[0]});
      check("limit source", {8'h0, input_limit_effective}, v[7] ? 16'h0020 : 16'h0040);
      rd(d);
      check("read back", d, v);
    end
    $display("test config done");
  endtask

  task automatic t_unmapped();
    logic g, a;
    logic [15:0] d;
    host.xfer(1'b0, 8'h30, 16'h0000, 2, g, a, d);
    check("unmapped read", {g, a, d[13:0]}, 16'h8000);
    host.xfer(1'b1, 8'h32, 16'hffff, 0, g, a, d);
    check("unmapped write ack", {14'h0, g, a}, 16'h0002);
    rd(d);
    check("unmapped no effect", d, 16'h00a2);
    $display("test unmapped done");
  endtask

  task automatic t_surge();
    logic [15:0] cfg [4] = '{16'h20b7, 16'h53b7, 16'he1b7, 16'h92b7};
    int mo [4] = '{1, 2, 20, 10};
    int mp [4] = '{5, 40, 10, 20};
    int ov, rc, er;
    for (int i = 0; i < 4; i++) begin
      wr(cfg[i]);
      fire(i % 2);
      ov = 0;
      rc = 0;
      while (overload_active === 1'b1 && ov < 400) begin
        ov++;
        drop();
      end
      while (recovery_active === 1'b1 && rc < 400) begin
        rc++;
        tick(1);
      end
      bound(ov + rc, 400);
      er = (mo[i] > mp[i]) ? 0 : (mp[i] - mo[i]) * MS;
      check("overload cycles", 16'(ov), 16'(mo[i] * MS));
      check("recovery cycles", 16'(rc), 16'(er));
      tick(2);
    end
    $display("test surge done");
  endtask

  task automatic t_sources();
    wr(16'h10b7);
    @(posedge clk) input_current_overshoot <= 1'b1;
    tick(10);
    ok("other source ignored", overload_active === 1'b0);
    drop();
    wr(16'h00b7);
    @(posedge clk) {input_current_overshoot, rail_droop} <= 2'b11;
    tick(10);
    ok("both disabled", overload_active === 1'b0);
    drop();
    tick(3);
    $display("test sources done");
  endtask

  task automatic t_flags();
    logic [15:0] d;
    int n;
    wr(16'he3b7);
    fire(0);
    drop();
    rd(d);
    check("overload flag", d, 16'hebb7);
    wr(16'he3b7);
    tick(1);
    ok("host ends overload", overload_active === 1'b0 && recovery_active === 1'b0);
    fire(0);
    drop();
    for (n = 0; n < 120 && recovery_active !== 1'b1; n++) tick(1);
    bound(n, 120);
    rd(d);
    check("recovery flag", d, 16'he7b7);
    wr(16'he3b7);
    tick(1);
    ok("host ends recovery", recovery_active === 1'b0);
    wr(16'hefb7);
    rd(d);
    check("flag ones ignored", d, 16'he3b7);
    ok("no phase from write", overload_active === 1'b0);
    $display("test flags done");
  endtask

  task automatic t_adapter();
    logic [15:0] d;
    wr(16'h30b7);
    @(posedge clk) adapter_present <= 1'b0;
    tick(6);
    rd(d);
    check("removal clears arms", d, 16'h00b7);
    @(posedge clk) adapter_present <= 1'b1;
    tick(3);
    $display("test adapter done");
  endtask

  task automatic t_overcurrent();
    logic seen;
    int n;
    wr(16'h02bf);
    seen = 1'b0;
    for (n = 0; n < 12; n++) begin
      @(posedge clk);
      input_overcurrent <= (n < 4);
      #1;
      seen = seen | converter_disable;
    end
    ok("short pulse blanked", seen === 1'b0);
    @(posedge clk) input_overcurrent <= 1'b1;
    #1;
    for (n = 0; n < 40 && converter_disable !== 1'b1; n++) tick(1);
    bound(n, 40);
    ok("stop after blank-out", n >= BLANK && n <= BLANK + 5);
    @(posedge clk) input_overcurrent <= 1'b0;
    tick(4);
    ok("input trip released", converter_disable === 1'b0);
    @(posedge clk) discharge_overcurrent <= 1'b1;
    tick(4);
    ok("discharge stop", converter_disable === 1'b1);
    wr(16'h02bd);
    tick(3);
    ok("discharge stop off", converter_disable === 1'b0);
    wr(16'h02b5);
    @(posedge clk) input_overcurrent <= 1'b1;
    tick(15);
    ok("input stop off", converter_disable === 1'b0);
    @(posedge clk) {input_overcurrent, discharge_overcurrent} <= 2'b00;
    tick(3);
    $display("test overcurrent done");
  endtask

  task automatic t_soft_reset();
    logic g, a;
    logic [15:0] d;
    int n;
    @(posedge clk) ce <= 1'b0;
    host.xfer(1'b1, 8'h31, 16'h0000, 0, g, a, d);
    check("frozen answer", {14'h0, g, a}, 16'h0000);
    @(posedge clk) ce <= 1'b1;
    rd(d);
    check("frozen register", d, 16'h02b5);
    wr(16'h2000);
    fire(0);
    drop();
    @(posedge clk) soft_reset_req <= 1'b1;
    @(posedge clk) soft_reset_req <= 1'b0;
    #1;
    for (n = 0; n < 3 && reg_reset_clear !== 1'b1; n++) tick(1);
    ok("reset bit cleared", n < 3);
    ok("soft reset ends phase", overload_active === 1'b0 && recovery_active === 1'b0);
    rd(d);
    check("soft reset value", d, 16'h02b7);
    $display("test soft reset done");
  endtask

  // stimulus: reset, then every scenario in turn
  initial begin
    rstn = 1'b0;
    ce = 1'b1;
    soft_reset_req = 1'b0;
    adapter_present = 1'b1;
    input_current_overshoot = 1'b0;
    rail_droop = 1'b0;
    input_overcurrent = 1'b0;
    discharge_overcurrent = 1'b0;
    limit_pin = 8'h20;
    input_limit_setting = 8'h40;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    tick(3);
    t_reset();
    t_config();
    t_unmapped();
    t_surge();
    t_sources();
    t_flags();
    t_adapter();
    t_overcurrent();
    t_soft_reset();
    end_of_test();
  end

  // watchdog against a hung run
  initial begin
    repeat (20000) @(posedge clk);
    check("run finished", 16'h0000, 16'h0001);
    end_of_test();
  end
endmodule
